// ---- inc/bcl_params.svh ----
`ifndef BCL_PARAMS_SVH
`define BCL_PARAMS_SVH

// clock rate and the window after reset release in which the bus is probed
`define BCL_CLK_MHZ         20
`define BCL_PROBE_NS        1000
`define BCL_PROBE_CYC       ((`BCL_PROBE_NS * `BCL_CLK_MHZ + 999) / 1000)

// serial target address, 7 bits
`define BCL_TGT_ADDR        7'h2C

// register offsets
`define BCL_OFS_AC_LVL      8'h01
`define BCL_OFS_CFG_HOLD    8'h03
`define BCL_OFS_DC_LVL      8'h0E

// field positions
`define BCL_AC_LSB          4
`define BCL_AC_MSB          6
`define BCL_DC_LSB          0
`define BCL_DC_MSB          2
`define BCL_CFG_HOLD_BIT    0

// dc level encodings
`define BCL_DC_LOW          3'h3
`define BCL_DC_MID          3'h5
`define BCL_DC_HIGH         3'h7

// ac level encodings, levels 0 to 3
`define BCL_AC_L0           3'h0
`define BCL_AC_L1           3'h1
`define BCL_AC_L2           3'h3
`define BCL_AC_L3           3'h7

// tri-level dc strap codes as delivered by the pin decoder
`define BCL_STRAP_L         2'h0
`define BCL_STRAP_M         2'h1
`define BCL_STRAP_H         2'h2

`define BCL_CFG_HOLD_RST    1'b1

`endif

// ---- inc/bcl_pkg.sv ----
`default_nettype none

package bcl_pkg;

	// top sequencer: shutdown, bus probe window, running
	typedef enum logic [1:0] {
		SEQ_SHUT,
		SEQ_PROBE,
		SEQ_RUN
	} bcl_seq_st_t;

	// serial target byte engine
	typedef enum logic [2:0] {
		TGT_IDLE,
		TGT_ADDR,
		TGT_ACK_A,
		TGT_WR,
		TGT_ACK_W,
		TGT_RD,
		TGT_ACK_R
	} bcl_tgt_st_t;

endpackage : bcl_pkg

`default_nettype wire

// ---- inc/bcl_reg_if.sv ----
`default_nettype none

// register access path between the serial target and the register file
interface bcl_reg_if;
	logic       en;
	logic       wr_en;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;

	modport tgt (
		input  en,
		input  rdata,
		output wr_en,
		output addr,
		output wdata
	);

	modport regs (
		output en,
		output rdata,
		input  wr_en,
		input  addr,
		input  wdata
	);
endinterface : bcl_reg_if

`default_nettype wire

// ---- logic/bcl_i2c_tgt.sv ----
`include "bcl_params.svh"
`default_nettype none

module bcl_i2c_tgt (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic scl,
	input  wire logic sda_i,
	output logic      sda_o,
	output logic      sda_oe,
	bcl_reg_if.tgt    rb
);

	bcl_pkg::bcl_tgt_st_t st_r, st_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic [7:0] ptr_r, ptr_nxt;
	logic       first_r, first_nxt;
	logic       rw_r, rw_nxt;
	logic       oe_r, oe_nxt;
	logic       wr_r, wr_nxt;
	logic [7:0] wd_r, wd_nxt;
	logic       scl_q, sda_q;
	logic       rise, fall, start, stop;

	// bus edges and framing conditions
	assign rise  = scl & ~scl_q;
	assign fall  = ~scl & scl_q;
	assign start = scl & scl_q & sda_q & ~sda_i;
	assign stop  = scl & scl_q & ~sda_q & sda_i;

	// open drain: only ever pull low
	assign sda_o    = 1'b0;
	assign sda_oe   = oe_r;
	assign rb.wr_en = wr_r;
	assign rb.addr  = ptr_r;
	assign rb.wdata = wd_r;

	// byte engine next state
	always_comb begin
		st_nxt    = st_r;
		cnt_nxt   = cnt_r;
		sh_nxt    = sh_r;
		ptr_nxt   = ptr_r;
		first_nxt = first_r;
		rw_nxt    = rw_r;
		oe_nxt    = oe_r;
		wr_nxt    = 1'b0;
		wd_nxt    = wd_r;
		if (!rb.en || stop) begin
			st_nxt = bcl_pkg::TGT_IDLE;
			oe_nxt = 1'b0;
		end else if (start) begin
			st_nxt    = bcl_pkg::TGT_ADDR;
			cnt_nxt   = 4'h0;
			first_nxt = 1'b1;
			oe_nxt    = 1'b0;
		end else begin
			case (st_r)
				bcl_pkg::TGT_ADDR, bcl_pkg::TGT_WR: begin
					if (rise) begin
						sh_nxt  = {sh_r[6:0], sda_i};
						cnt_nxt = cnt_r + 4'h1;
					end else if (fall && cnt_r == 4'h8) begin
						if (st_r == bcl_pkg::TGT_ADDR) begin
							// foreign address: stay off the bus
							if (sh_r[7:1] == `BCL_TGT_ADDR) begin
								st_nxt = bcl_pkg::TGT_ACK_A;
								oe_nxt = 1'b1;
								rw_nxt = sh_r[0];
							end else begin
								st_nxt = bcl_pkg::TGT_IDLE;
							end
						end else begin
							st_nxt = bcl_pkg::TGT_ACK_W;
							oe_nxt = 1'b1;
							// first data byte is the register pointer
							if (first_r) begin
								ptr_nxt   = sh_r;
								first_nxt = 1'b0;
							end else begin
								wr_nxt  = 1'b1;
								wd_nxt  = sh_r;
							end
						end
					end
				end
				bcl_pkg::TGT_ACK_A: begin
					if (fall) begin
						cnt_nxt = 4'h0;
						if (rw_r) begin
							st_nxt = bcl_pkg::TGT_RD;
							sh_nxt = rb.rdata;
							oe_nxt = ~rb.rdata[7];
						end else begin
							st_nxt = bcl_pkg::TGT_WR;
							oe_nxt = 1'b0;
						end
					end
				end
				bcl_pkg::TGT_ACK_W: begin
					if (fall) begin
						// auto increment after each stored byte
						if (wr_r) ptr_nxt = ptr_r + 8'h01;
						st_nxt  = bcl_pkg::TGT_WR;
						cnt_nxt = 4'h0;
						oe_nxt  = 1'b0;
					end else if (wr_r) begin
						ptr_nxt = ptr_r + 8'h01;
					end
				end
				bcl_pkg::TGT_RD: begin
					if (fall) begin
						if (cnt_r == 4'h7) begin
							st_nxt  = bcl_pkg::TGT_ACK_R;
							oe_nxt  = 1'b0;
							ptr_nxt = ptr_r + 8'h01;
						end else begin
							sh_nxt  = {sh_r[6:0], 1'b0};
							oe_nxt  = ~sh_r[6];
							cnt_nxt = cnt_r + 4'h1;
						end
					end
				end
				bcl_pkg::TGT_ACK_R: begin
					// master nack ends the read burst
					if (rise && sda_i) begin
						st_nxt = bcl_pkg::TGT_IDLE;
					end else if (fall) begin
						st_nxt  = bcl_pkg::TGT_RD;
						cnt_nxt = 4'h0;
						sh_nxt  = rb.rdata;
						oe_nxt  = ~rb.rdata[7];
					end
				end
				default: st_nxt = bcl_pkg::TGT_IDLE;
			endcase
		end
	end

	// byte engine registers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_r    <= bcl_pkg::TGT_IDLE;
			cnt_r   <= 4'h0;
			sh_r    <= 8'h00;
			ptr_r   <= 8'h00;
			first_r <= 1'b0;
			rw_r    <= 1'b0;
			oe_r    <= 1'b0;
			wr_r    <= 1'b0;
			wd_r    <= 8'h00;
			scl_q   <= 1'b1;
			sda_q   <= 1'b1;
		end else begin
			st_r    <= st_nxt;
			cnt_r   <= cnt_nxt;
			sh_r    <= sh_nxt;
			ptr_r   <= ptr_nxt;
			first_r <= first_nxt;
			rw_r    <= rw_nxt;
			oe_r    <= oe_nxt;
			wr_r    <= wr_nxt;
			wd_r    <= wd_nxt;
			scl_q   <= scl;
			sda_q   <= sda_i;
		end
	end

endmodule : bcl_i2c_tgt

`default_nettype wire

// ---- logic/bcl_cfg_latch.sv ----
// Overview of operation
// - The dc gain level is a three-bit read/write field in bits 2:0 at 0x0E.
// - Dc level 011 is 40 mV, 101 is 60 mV (default), 111 is 80 mV.
// - At reset the dc level is loaded from the tri-level dc strap.
// - Straps are captured once per reset and ignored until the next one.
// - The ac level lives in bits 6:4 at 0x01, loaded from the ac strap.
// - Bus access at target 0x2C needs both lines high at the end of the probe window after release.
`include "bcl_params.svh"
`default_nettype none

module bcl_cfg_latch #(
	parameter int PROBE_CYC = `BCL_PROBE_CYC
) (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       active_low_reset_pin,
	input  wire logic [1:0] dc_gain_strap,
	input  wire logic [1:0] ac_gain_strap,
	input  wire logic       scl,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe,
	output logic [2:0]      dc_gain_level,
	output logic [2:0]      ac_gain_level,
	output logic            eq_enable,
	output logic            i2c_mode
);

	// window length must fit the 16-bit probe counter
	if (PROBE_CYC < 1 || PROBE_CYC > 65535) begin : g_probe_chk
		$error("PROBE_CYC out of range");
	end

	bcl_reg_if rb ();

	bcl_pkg::bcl_seq_st_t seq_r, seq_nxt;
	logic [15:0] pcnt_r, pcnt_nxt;
	logic [2:0]  dc_r, dc_nxt;
	logic [2:0]  ac_r, ac_nxt;
	logic        hold_r, hold_nxt;
	logic        i2c_r, i2c_nxt;
	logic        en_r, en_nxt;
	logic [2:0]  dc_strap_enc;
	logic [2:0]  ac_strap_enc;
	logic        capture;
	logic        probe_end;
	logic        lines_hi;
	logic        host_wr;

	// strap decode to register patterns; an illegal dc code falls to mid
	always_comb begin
		case (dc_gain_strap)
			`BCL_STRAP_L: dc_strap_enc = `BCL_DC_LOW;
			`BCL_STRAP_H: dc_strap_enc = `BCL_DC_HIGH;
			default:      dc_strap_enc = `BCL_DC_MID;
		endcase
	end

	// ac strap: four resistor levels map to a thermometer pattern
	always_comb begin
		case (ac_gain_strap)
			2'h0:    ac_strap_enc = `BCL_AC_L0;
			2'h1:    ac_strap_enc = `BCL_AC_L1;
			2'h2:    ac_strap_enc = `BCL_AC_L2;
			default: ac_strap_enc = `BCL_AC_L3;
		endcase
	end

	// strap capture, probe end and host write, each gated by the pin
	assign capture   = active_low_reset_pin && seq_r == bcl_pkg::SEQ_SHUT;
	assign probe_end = active_low_reset_pin &&
		seq_r == bcl_pkg::SEQ_PROBE && pcnt_r == 16'(PROBE_CYC - 1);
	assign lines_hi  = scl & sda_i;
	assign host_wr   = active_low_reset_pin && seq_r == bcl_pkg::SEQ_RUN &&
		rb.wr_en && i2c_r;

	// reset sequencer next state; a low pin wins over every state
	always_comb begin
		seq_nxt  = seq_r;
		pcnt_nxt = pcnt_r;
		i2c_nxt  = i2c_r;
		en_nxt   = en_r;
		if (!active_low_reset_pin) begin
			// shutdown: no boost, bus closed; straps reread on release
			seq_nxt = bcl_pkg::SEQ_SHUT;
			i2c_nxt = 1'b0;
			en_nxt  = 1'b0;
		end else begin
			case (seq_r)
				bcl_pkg::SEQ_SHUT: begin
					// single capture point; later strap moves are ignored
					pcnt_nxt = 16'h0000;
					seq_nxt  = bcl_pkg::SEQ_PROBE;
				end
				bcl_pkg::SEQ_PROBE: begin
					if (probe_end) begin
						// both lines high at window end opens the bus
						i2c_nxt = lines_hi;
						seq_nxt = bcl_pkg::SEQ_RUN;
					end else begin
						pcnt_nxt = pcnt_r + 16'h0001;
					end
				end
				bcl_pkg::SEQ_RUN: begin
					// boost restarts once the hold bit is cleared
					en_nxt = ~hold_nxt;
				end
				default: seq_nxt = bcl_pkg::SEQ_SHUT;
			endcase
		end
	end

	// sequencer state
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			seq_r  <= bcl_pkg::SEQ_SHUT;
			pcnt_r <= 16'h0000;
			i2c_r  <= 1'b0;
			en_r   <= 1'b0;
		end else begin
			seq_r  <= seq_nxt;
			pcnt_r <= pcnt_nxt;
			i2c_r  <= i2c_nxt;
			en_r   <= en_nxt;
		end
	end

	// register file next values; levels hold through shutdown and are
	// overwritten at release
	always_comb begin
		dc_nxt   = dc_r;
		ac_nxt   = ac_r;
		hold_nxt = hold_r;
		if (capture) begin
			dc_nxt   = dc_strap_enc;
			ac_nxt   = ac_strap_enc;
			hold_nxt = `BCL_CFG_HOLD_RST;
		end else if (probe_end && !lines_hi) begin
			// no host on the bus could ever clear the hold bit
			hold_nxt = 1'b0;
		end else if (host_wr) begin
			case (rb.addr)
				`BCL_OFS_DC_LVL:
					dc_nxt = rb.wdata[`BCL_DC_MSB:`BCL_DC_LSB];
				`BCL_OFS_AC_LVL:
					ac_nxt = rb.wdata[`BCL_AC_MSB:`BCL_AC_LSB];
				`BCL_OFS_CFG_HOLD:
					hold_nxt = rb.wdata[`BCL_CFG_HOLD_BIT];
				default: ;
			endcase
		end
	end

	// register file state; dc resets to mid and ac to level 0, both only
	// until the first capture after release
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dc_r   <= `BCL_DC_MID;
			ac_r   <= `BCL_AC_L0;
			hold_r <= `BCL_CFG_HOLD_RST;
		end else begin
			dc_r   <= dc_nxt;
			ac_r   <= ac_nxt;
			hold_r <= hold_nxt;
		end
	end

	// read mux; reserved bits and unmapped offsets read zero
	always_comb begin
		rb.rdata = 8'h00;
		case (rb.addr)
			`BCL_OFS_DC_LVL:
				rb.rdata[`BCL_DC_MSB:`BCL_DC_LSB] = dc_r;
			`BCL_OFS_AC_LVL:
				rb.rdata[`BCL_AC_MSB:`BCL_AC_LSB] = ac_r;
			`BCL_OFS_CFG_HOLD:
				rb.rdata[`BCL_CFG_HOLD_BIT] = hold_r;
			default: rb.rdata = 8'h00;
		endcase
	end

	// outputs straight from flip-flops
	assign rb.en         = i2c_r;
	assign dc_gain_level = dc_r;
	assign ac_gain_level = ac_r;
	assign eq_enable     = en_r;
	assign i2c_mode      = i2c_r;

	// serial target; closed whenever the bus probe failed
	bcl_i2c_tgt u_tgt (
		.ref_clk (ref_clk),
		.rst     (rst),
		.scl     (scl),
		.sda_i   (sda_i),
		.sda_o   (sda_o),
		.sda_oe  (sda_oe),
		.rb      (rb)
	);

endmodule : bcl_cfg_latch

`default_nettype wire

// ---- dv/bcl_host_model.sv ----
`default_nettype none

// serial host: open drain, bit time 16 clocks
module bcl_host_model (
	input wire logic ref_clk,
	input wire logic sda_i,
	output logic     scl,
	output logic     sda_dn
);
	timeunit 1ns;
	timeprecision 1ns;

	// idle bus, both lines released
	initial begin
		scl = 1'h1;
		sda_dn = 1'h0;
	end

	task automatic tk(input int n);
		repeat (n) @(posedge ref_clk);
		#2;
	endtask : tk

	// data moves only while scl is low
	task automatic bt(input logic b, output logic r);
		sda_dn = !b;
		tk(4);
		scl = 1'h1;
		tk(4);
		r = sda_i;
		tk(4);
		scl = 1'h0;
		tk(4);
	endtask : bt

	// also serves as repeated start
	task automatic start();
		sda_dn = 1'h0;
		tk(4);
		scl = 1'h1;
		tk(4);
		sda_dn = 1'h1;
		tk(4);
		scl = 1'h0;
		tk(4);
	endtask : start

	task automatic stop();
		sda_dn = 1'h1;
		tk(4);
		scl = 1'h1;
		tk(4);
		sda_dn = 1'h0;
		tk(4);
	endtask : stop

	// byte msb first, then the ack bit m
	task automatic xfer(input logic [7:0] d, input logic m,
		output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--)
			bt(d[i], q[i]);
		bt(m, a);
	endtask : xfer
endmodule : bcl_host_model

`default_nettype wire

// ---- dv/bcl_cfg_monitor.sv ----
`default_nettype none

module bcl_cfg_monitor #(
	parameter int PROBE_CYC = 20
) (
	input wire logic       ref_clk,
	input wire logic       rst,
	input wire logic       active_low_reset_pin,
	input wire logic [1:0] dc_gain_strap,
	input wire logic [1:0] ac_gain_strap,
	input wire logic       scl,
	input wire logic       sda_i,
	input wire logic       sda_o,
	input wire logic       sda_oe,
	input wire logic [2:0] dc_gain_level,
	input wire logic [2:0] ac_gain_level,
	input wire logic       eq_enable,
	input wire logic       i2c_mode
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	logic [2:0] dc_map;
	logic [2:0] ac_map;

	// strap to field, illegal dc code reads as mid
	assign dc_map = dc_gain_strap == 2'h0 ? 3'h3 :
		dc_gain_strap == 2'h2 ? 3'h7 : 3'h5;
	assign ac_map = {ac_gain_strap == 2'h3, ac_gain_strap[1], |ac_gain_strap};

	// edges since pin release, saturates so it never wraps
	always_comb begin
		cnt_nxt = cnt_r;
		if (!active_low_reset_pin)
			cnt_nxt = 8'h00;
		else if (cnt_r != 8'hFF)
			cnt_nxt = cnt_r + 8'h01;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			cnt_r <= 8'h00;
		else
			cnt_r <= cnt_nxt;
	end

	default clocking mcb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	a_dc_strap_load: assert property ($rose(active_low_reset_pin) |=>
		dc_gain_level == $past(dc_map)) else $error("dc not from strap");
	a_ac_strap_load: assert property ($rose(active_low_reset_pin) |=>
		ac_gain_level == $past(ac_map)) else $error("ac not from strap");
	a_strap_ignored: assert property (cnt_r > 8'h01 && !i2c_mode &&
		!$past(i2c_mode) |-> $stable(dc_gain_level) && $stable(ac_gain_level))
		else $error("levels moved after capture");
	a_shut_quiet: assert property (!active_low_reset_pin |=>
		!eq_enable && !i2c_mode) else $error("active while pin low");
	a_probe_wait: assert property (cnt_r <= PROBE_CYC |->
		!eq_enable && !i2c_mode) else $error("mode before probe");
	a_probe_fail: assert property (cnt_r == PROBE_CYC + 4 && !i2c_mode |->
		eq_enable) else $error("hold not cleared");
	a_probe_lines: assert property ($rose(i2c_mode) |->
		$past(scl) && $past(sda_i)) else $error("mode without lines high");
	a_hold_kept: assert property ($rose(i2c_mode) |-> !eq_enable [*8])
		else $error("eq without hold clear");
	a_bus_silent: assert property (!i2c_mode && !$past(i2c_mode) |->
		!sda_oe) else $error("sda driven outside mode");
	a_drive_scl_low: assert property ($rose(sda_oe) |-> !scl && !$past(scl))
		else $error("sda driven while scl high");

	c_i2c: cover property ($rose(i2c_mode));
	c_eq_host: cover property ($rose(eq_enable) && i2c_mode);
	c_ack: cover property ($rose(sda_oe));
endmodule : bcl_cfg_monitor

bind bcl_cfg_latch bcl_cfg_monitor #(.PROBE_CYC(PROBE_CYC)) i_mon (
	.ref_clk, .rst, .active_low_reset_pin, .dc_gain_strap, .ac_gain_strap,
	.scl, .sda_i, .sda_o, .sda_oe, .dc_gain_level, .ac_gain_level,
	.eq_enable, .i2c_mode
);

`default_nettype wire

// ---- dv/test_boost_strap_config_latch.sv ----
`include "bcl_params.svh"
`default_nettype none

`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
	miscompares++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end

module test_boost_strap_config_latch;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int P = 2;
	logic        ref_clk;
	logic        rst;
	logic        pin;
	logic [1:0]  dc_s;
	logic [1:0]  ac_s;
	logic        scl;
	logic        sda_i;
	logic        sda_o;
	logic        sda_oe;
	logic        sda_dn;
	logic        bus_lo;
	logic [2:0]  dc;
	logic [2:0]  ac;
	logic        eq;
	logic        im;
	logic [7:0]  q;
	logic [7:0]  d;
	logic        a;
	int          miscompares = 0;
	int          cmp_count = 0;
	int unsigned seed = 16293;

	// pull-up on sda, bus_lo fails the probe
	assign sda_i = !(sda_oe || sda_dn || bus_lo);

	bcl_cfg_latch #(.PROBE_CYC(P)) i_dut (.ref_clk(ref_clk), .rst(rst),
		.active_low_reset_pin(pin), .dc_gain_strap(dc_s),
		.ac_gain_strap(ac_s), .scl(scl), .sda_i(sda_i), .sda_o(sda_o),
		.sda_oe(sda_oe), .dc_gain_level(dc), .ac_gain_level(ac),
		.eq_enable(eq), .i2c_mode(im));

	bcl_host_model i_host (.ref_clk(ref_clk), .sda_i(sda_i), .scl(scl),
		.sda_dn(sda_dn));

	initial begin
		ref_clk = 1'h0;
		forever #25 ref_clk = ~ref_clk;
	end

	function automatic int unsigned rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic logic [2:0] dc_exp(input logic [1:0] s);
		return s == `BCL_STRAP_L ? `BCL_DC_LOW :
			s == `BCL_STRAP_H ? `BCL_DC_HIGH : `BCL_DC_MID;
	endfunction : dc_exp

	function automatic logic [2:0] ac_exp(input logic [1:0] s);
		return {s == 2'h3, s[1], |s};
	endfunction : ac_exp

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#2;
	endtask : cyc

	task automatic wb(input logic [7:0] b);
		i_host.xfer(b, 1'h1, q, a);
		`CHK("ack", 1'h0, a)
	endtask : wb

	task automatic wr(input logic [7:0] o, input logic [7:0] v);
		i_host.start();
		wb({`BCL_TGT_ADDR, 1'h0});
		wb(o);
		wb(v);
		i_host.stop();
	endtask : wr

	// pointer set, repeated start, one byte then nack
	task automatic rd(input logic [7:0] o);
		i_host.start();
		wb({`BCL_TGT_ADDR, 1'h0});
		wb(o);
		i_host.start();
		wb({`BCL_TGT_ADDR, 1'h1});
		i_host.xfer(8'hFF, 1'h1, q, a);
		i_host.stop();
	endtask : rd

	// pin toggle with new straps; later strap moves must not land
	task automatic boot(input logic [1:0] s, input logic [1:0] c,
		input logic hi);
		pin = 1'h0;
		cyc(3);
		dc_s = s;
		ac_s = c;
		bus_lo = !hi;
		pin = 1'h1;
		cyc(P + 6);
		`CHK("dc", dc_exp(s), dc)
		`CHK("ac", ac_exp(c), ac)
		`CHK("i2c", hi, im)
		`CHK("eq", !hi, eq)
		bus_lo = 1'h0;
		dc_s = ~s;
		ac_s = ~c;
		cyc(4);
		`CHK("dc held", dc_exp(s), dc)
		`CHK("ac held", ac_exp(c), ac)
	endtask : boot

	task automatic test_done;
		if (miscompares == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done

	// hang guard, well past the expected run
	initial begin
		cyc(30000);
		miscompares++;
		test_done;
	end

	initial begin
		rst = 1'h1;
		pin = 1'h0;
		dc_s = 2'h0;
		ac_s = 2'h0;
		bus_lo = 1'h0;
		cyc(10);
		rst = 1'h0;
		cyc(2);
		boot(2'(rnd()), 2'(rnd()), 1'h1);
		for (int i = 0; i < 3; i++) begin
			d = i == 0 ? 8'h03 : 8'(rnd());
			wr(`BCL_OFS_DC_LVL, d);
			`CHK("dc wr", d[2:0], dc)
			rd(`BCL_OFS_DC_LVL);
			`CHK("dc rd", {5'h00, d[2:0]}, q)
			wr(`BCL_OFS_AC_LVL, d);
			`CHK("ac wr", d[6:4], ac)
			rd(`BCL_OFS_AC_LVL);
			`CHK("ac rd", {1'h0, d[6:4], 4'h0}, q)
		end
		// foreign address is left unanswered
		i_host.start();
		i_host.xfer(8'h5A, 1'h1, q, a);
		`CHK("nack", 1'h1, a)
		i_host.stop();
		wr(`BCL_OFS_CFG_HOLD, 8'h01);
		`CHK("eq held", 1'h0, eq)
		rd(`BCL_OFS_CFG_HOLD);
		`CHK("hold rd", 8'h01, q)
		wr(`BCL_OFS_CFG_HOLD, 8'h00);
		cyc(4);
		`CHK("eq run", 1'h1, eq)
		for (int i = 0; i < 4; i++)
			boot(2'(i), 2'(3 - i), 1'h0);
		// failed probe keeps the bus closed even with both lines high now
		i_host.start();
		i_host.xfer({`BCL_TGT_ADDR, 1'h0}, 1'h1, q, a);
		`CHK("closed", 1'h1, a)
		i_host.stop();
		`CHK("sda_o", 1'h0, sda_o)
		// second chip reset mid-run
		rst = 1'h1;
		cyc(2);
		`CHK("dc rst", `BCL_DC_MID, dc)
		`CHK("ac rst", `BCL_AC_L0, ac)
		rst = 1'h0;
		cyc(2);
		// pin still high: the first edge after release captures the straps
		`CHK("dc cap", dc_exp(dc_s), dc)
		`CHK("ac cap", ac_exp(ac_s), ac)
		test_done;
	end
endmodule : test_boost_strap_config_latch

`default_nettype wire
